// ---- cfg_regs_pkg.sv ----
// constants and types for the configuration register bank
// assumes a single system clock domain, all users refer by pkg:: name
package cfg_regs_pkg;

  // ----------------------------------------------------------------
  // select code and address decode
  // ----------------------------------------------------------------
  // device type code: the value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'h5;
  localparam logic [2:0] SEL_CE_CFG       = 3'h6;
  localparam logic [2:0] SEL_WP_CFG       = 3'h5;
  localparam int         SEL_CE_BIT       = 3;
  localparam int         SEL_RW_BIT       = 0;

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  localparam int         CE_BIT       = 3;
  localparam int         ADDR_LOCK    = 0;
  localparam int         PROT_ACT     = 3;
  localparam int         BLK_HI       = 2;
  localparam int         BLK_LO       = 1;
  localparam int         PROT_LOCK    = 0;
  localparam logic [7:0] CE_CFG_MASK  = 8'h09;
  localparam logic [7:0] WP_CFG_MASK  = 8'h0f;
  localparam logic [7:0] FACTORY_VAL  = 8'h00;

  // block-size codes
  localparam logic [1:0] BLK_QUARTER  = 2'h0;
  localparam logic [1:0] BLK_HALF     = 2'h1;
  localparam logic [1:0] BLK_3QUARTER = 2'h2;
  localparam logic [1:0] BLK_ALL      = 2'h3;

  // ----------------------------------------------------------------
  // bus framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam int         ARRAY_AW     = 18;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_DEVSEL = 7'h02,
    ST_ADDR_H = 7'h04,
    ST_ADDR_L = 7'h08,
    ST_WDATA  = 7'h10,
    ST_RDATA  = 7'h20,
    ST_IGNORE = 7'h40
  } bus_state_type;

  // image of both registers as kept in nonvolatile storage
  typedef struct packed {
    logic [7:0] chip_enable_config;
    logic [7:0] write_protect_config;
  } nv_image_type;

endpackage : cfg_regs_pkg

// ---- cfg_regs_properties.sv ----
// port assertions for the configuration register bank
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/1ps
module cfg_regs_checker (
  input wire logic                       clk_sys_in,
  input wire logic                       rstn_in,
  input wire logic                       scl_in,
  input wire logic                       sda_in,
  input wire logic                       sda_out,
  input wire logic                       sda_oe_n_out,
  input wire logic                       write_inhibit_pin_in,
  input wire cfg_regs_pkg::nv_image_type nv_image_in,
  input wire cfg_regs_pkg::nv_image_type nv_image_out,
  input wire logic                       nv_store_out,
  input wire logic [17:0]                array_addr_in,
  input wire logic                       array_write_blocked_out
);
  logic prot_exp_r;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge clk_sys_in) begin
    prot_exp_r <= nv_image_out[3] && (int'(array_addr_in[17:16])
                  >= 3 - int'(nv_image_out[2:1]));
  end
  AST_RESET: assert property (disable iff (1'b0)
    !rstn_in |=> sda_oe_n_out && !nv_store_out && nv_image_out == 16'h0000)
    else $error("outputs not idle in reset");
  AST_UNUSED_ZERO: assert property (
    (nv_image_out & 16'hf6f0) == 16'h0000) else $error("unused bit set");
  AST_CE_LOCK: assert property (
    nv_image_out[8] |=> $stable(nv_image_out[15:8]))
    else $error("locked chip enable config changed");
  AST_WP_LOCK: assert property (
    nv_image_out[0] |=> $stable(nv_image_out[7:0]))
    else $error("locked write protect config changed");
  AST_LOAD: assert property (
    $rose(rstn_in) |=> nv_image_out == (nv_image_in & 16'h090f))
    else $error("stored image not loaded");
  AST_INHIBIT: assert property (
    write_inhibit_pin_in [*8] |-> !nv_store_out)
    else $error("store while inhibited");
  AST_SDA_SCL_LOW: assert property (
    $changed(sda_oe_n_out) |-> !scl_in) else $error("sda moved with scl high");
  AST_PROT: assert property (
    array_write_blocked_out == prot_exp_r) else $error("blocked flag wrong");
  AST_STORE_PULSE: assert property (
    nv_store_out |=> !nv_store_out) else $error("store pulse too long");
  AST_CHANGE_ON_STORE: assert property (
    $changed(nv_image_out) |-> nv_store_out || !$past(rstn_in, 2))
    else $error("register changed without commit");
  cover property (nv_store_out);
  cover property (array_write_blocked_out);
  cover property (nv_image_out[8] && nv_image_out[0]);
endmodule : cfg_regs_checker

bind eeprom_addr_and_wprot_regs cfg_regs_checker chk_u (.*);

// ---- eeprom_addr_and_wprot_regs.sv ----
// two lockable configuration registers of a serial-bus eeprom target
// assumes scl/sda/write-inhibit come from pins (synchronised here) and
// that the nonvolatile image and array address come from clk_sys logic
`timescale 1ns/1ps

module eeprom_addr_and_wprot_regs (
  input  wire logic                       clk_sys_in,
  input  wire logic                       rstn_in,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_n_out,
  input  wire logic                       write_inhibit_pin_in,
  input  wire cfg_regs_pkg::nv_image_type nv_image_in,
  output cfg_regs_pkg::nv_image_type      nv_image_out,
  output logic                            nv_store_out,
  input  wire logic [17:0]                array_addr_in,
  output logic                            array_write_blocked_out
);

  // ----------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic scl_meta_r, scl_s_r, scl_d_r;
  logic sda_meta_r, sda_s_r, sda_d_r;
  logic inh_meta_r, inh_s_r;

  // idle-high reset values keep a false start or stop out of reset
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      scl_meta_r <= 1'b1;
      scl_s_r    <= 1'b1;
      scl_d_r    <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_s_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      inh_meta_r <= 1'b0;
      inh_s_r    <= 1'b0;
    end else begin
      scl_meta_r <= scl_in;
      scl_s_r    <= scl_meta_r;
      scl_d_r    <= scl_s_r;
      sda_meta_r <= sda_in;
      sda_s_r    <= sda_meta_r;
      sda_d_r    <= sda_s_r;
      inh_meta_r <= write_inhibit_pin_in;
      inh_s_r    <= inh_meta_r;
    end
  end

  logic start_ev, stop_ev, scl_rise, scl_fall;
  assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_ev  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] ce_cfg_r, wp_cfg_r;
  logic       load_pend_r;
  logic       ce_lock, wp_lock;
  // lock flag at b0, chip-enable bit at b3
  assign ce_lock = ce_cfg_r[cfg_regs_pkg::ADDR_LOCK];
  assign wp_lock = wp_cfg_r[cfg_regs_pkg::PROT_LOCK];

  // ----------------------------------------------------------------
  // byte engine and transaction state
  // ----------------------------------------------------------------
  cfg_regs_pkg::bus_state_type st_r;
  logic [3:0] cnt_r;
  logic       ack_ph_r;
  logic [7:0] shift_r, tx_r, data_r;
  logic [2:0] sel_r;
  logic       pend_r, abort_r, drv_r;
  logic       dev_match, sel_ok, sel_locked;
  logic [7:0] sel_val;
  logic       commit;

  assign dev_match =
    (shift_r[7:4] == cfg_regs_pkg::DEVICE_TYPE_CODE) &&
    (shift_r[cfg_regs_pkg::SEL_CE_BIT] == ce_cfg_r[cfg_regs_pkg::CE_BIT]);
  assign sel_ok = (sel_r == cfg_regs_pkg::SEL_CE_CFG) ||
                  (sel_r == cfg_regs_pkg::SEL_WP_CFG);
  assign sel_locked = (sel_r == cfg_regs_pkg::SEL_CE_CFG) ? ce_lock
                                                          : wp_lock;
  assign sel_val = (sel_r == cfg_regs_pkg::SEL_CE_CFG) ? ce_cfg_r
                                                       : wp_cfg_r;
  // no busy window: the write lands at the stop itself
  // commit on stop
  assign commit = stop_ev && pend_r && !abort_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      st_r     <= cfg_regs_pkg::ST_IDLE;
      cnt_r    <= 4'h0;
      ack_ph_r <= 1'b0;
      shift_r  <= 8'h00;
      tx_r     <= 8'h00;
      data_r   <= 8'h00;
      sel_r    <= 3'h0;
      pend_r   <= 1'b0;
      abort_r  <= 1'b0;
      drv_r    <= 1'b0;
    end else if (start_ev) begin
      // repeated start keeps sel_r for the random-read format
      st_r     <= cfg_regs_pkg::ST_DEVSEL;
      cnt_r    <= 4'h0;
      ack_ph_r <= 1'b0;
      pend_r   <= 1'b0;
      abort_r  <= 1'b0;
      drv_r    <= 1'b0;
    end else if (stop_ev) begin
      st_r     <= cfg_regs_pkg::ST_IDLE;
      ack_ph_r <= 1'b0;
      pend_r   <= 1'b0;
      drv_r    <= 1'b0;
    end else if (scl_rise) begin
      if (st_r == cfg_regs_pkg::ST_RDATA && !ack_ph_r) begin
        if (cnt_r < cfg_regs_pkg::BYTE_BITS) begin
          cnt_r <= cnt_r + 4'h1;
        end else if (sda_s_r) begin
          // controller nack ends the read
          st_r <= cfg_regs_pkg::ST_IGNORE;
        end else begin
          cnt_r <= 4'h0;
          tx_r  <= sel_val;
        end
      end else if (st_r != cfg_regs_pkg::ST_IDLE &&
                   st_r != cfg_regs_pkg::ST_IGNORE &&
                   !ack_ph_r && cnt_r < cfg_regs_pkg::BYTE_BITS) begin
        shift_r <= {shift_r[6:0], sda_s_r};
        cnt_r   <= cnt_r + 4'h1;
      end
    end else if (scl_fall) begin
      if (ack_ph_r) begin
        ack_ph_r <= 1'b0;
        cnt_r    <= 4'h0;
        drv_r    <= (st_r == cfg_regs_pkg::ST_RDATA) ? ~tx_r[7] : 1'b0;
      end else if (st_r == cfg_regs_pkg::ST_RDATA) begin
        // open drain: a one is sent by releasing the line
        if (cnt_r < cfg_regs_pkg::BYTE_BITS) begin
          drv_r <= ~tx_r[3'h7 - cnt_r[2:0]];
        end else begin
          drv_r <= 1'b0;
        end
      end else if (cnt_r == cfg_regs_pkg::BYTE_BITS) begin
        ack_ph_r <= 1'b1;
        case (st_r)
          cfg_regs_pkg::ST_DEVSEL: begin
            if (dev_match) begin
              drv_r <= 1'b1;
              tx_r  <= sel_val;
              st_r  <= shift_r[cfg_regs_pkg::SEL_RW_BIT]
                       ? cfg_regs_pkg::ST_RDATA
                       : cfg_regs_pkg::ST_ADDR_H;
            end else begin
              drv_r <= 1'b0;
              st_r  <= cfg_regs_pkg::ST_IGNORE;
            end
          end
          cfg_regs_pkg::ST_ADDR_H: begin
            // only A15..A13 kept, the rest ignored
            drv_r <= 1'b1;
            sel_r <= shift_r[7:5];
            st_r  <= cfg_regs_pkg::ST_ADDR_L;
          end
          cfg_regs_pkg::ST_ADDR_L: begin
            // address bytes acked even when locked
            drv_r <= 1'b1;
            st_r  <= cfg_regs_pkg::ST_WDATA;
          end
          cfg_regs_pkg::ST_WDATA: begin
            if (pend_r) begin
              // second data byte aborts the write
              abort_r <= 1'b1;
              pend_r  <= 1'b0;
              drv_r   <= 1'b0;
            end else if (!inh_s_r && sel_ok && !sel_locked) begin
              pend_r <= 1'b1;
              data_r <= shift_r;
              drv_r  <= 1'b1;
            end else begin
              // data byte refused, no write cycle
              drv_r <= 1'b0;
              st_r  <= cfg_regs_pkg::ST_IGNORE;
            end
          end
          default: begin
            drv_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // nonvolatile image is taken one cycle after reset release
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      // factory value until the image loads
      ce_cfg_r    <= cfg_regs_pkg::FACTORY_VAL;
      wp_cfg_r    <= cfg_regs_pkg::FACTORY_VAL;
      load_pend_r <= 1'b1;
    end else if (load_pend_r) begin
      // reload, unused bits forced to zero
      ce_cfg_r    <= nv_image_in.chip_enable_config &
                     cfg_regs_pkg::CE_CFG_MASK;
      wp_cfg_r    <= nv_image_in.write_protect_config &
                     cfg_regs_pkg::WP_CFG_MASK;
      load_pend_r <= 1'b0;
    end else if (commit) begin
      // locks only rise here; a fresh image is the sole way back
      // chip-enable config, both bits in one write
      if (sel_r == cfg_regs_pkg::SEL_CE_CFG && !ce_lock) begin
        ce_cfg_r <= data_r & cfg_regs_pkg::CE_CFG_MASK;
      end
      if (sel_r == cfg_regs_pkg::SEL_WP_CFG && !wp_lock) begin
        wp_cfg_r <= data_r & cfg_regs_pkg::WP_CFG_MASK;
      end
    end
  end

  // store request toward the nonvolatile array, one cycle per commit
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      nv_store_out <= 1'b0;
    end else begin
      nv_store_out <= commit && !load_pend_r && !sel_locked;
    end
  end

  // one driver for the whole image, both fields already masked
  assign nv_image_out = '{chip_enable_config:   ce_cfg_r,
                          write_protect_config: wp_cfg_r};

  // ----------------------------------------------------------------
  // array write protection
  // ----------------------------------------------------------------
  logic [1:0] blk;
  logic [1:0] top2;
  logic       in_region;
  assign blk  = {wp_cfg_r[cfg_regs_pkg::BLK_HI],
                 wp_cfg_r[cfg_regs_pkg::BLK_LO]};
  assign top2 = array_addr_in[cfg_regs_pkg::ARRAY_AW-1 -: 2];

  // each code moves the lower bound down by one quarter
  // region from the two top address bits
  always_comb begin
    case (blk)
      cfg_regs_pkg::BLK_QUARTER:  in_region = (top2 == 2'h3);
      cfg_regs_pkg::BLK_HALF:     in_region = top2[1];
      cfg_regs_pkg::BLK_3QUARTER: in_region = (top2 != 2'h0);
      cfg_regs_pkg::BLK_ALL:      in_region = 1'b1;
      default:                    in_region = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      array_write_blocked_out <= 1'b0;
    end else begin
      array_write_blocked_out <= wp_cfg_r[cfg_regs_pkg::PROT_ACT] &&
                                 in_region;
    end
  end

  // ----------------------------------------------------------------
  // open-drain data pin
  // ----------------------------------------------------------------
  // only a low is ever driven; a one is left to the pull-up
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~drv_r;

endmodule : eeprom_addr_and_wprot_regs

// ---- i2c_ctrl_model.sv ----
// bus controller model issuing register frames to the target
// assumes the bench resolves sda with a pull-up and the target's pull-down
`timescale 1ns/1ps
module i2c_ctrl_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic odd_r;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    odd_r   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // scl high six cycles, low six or seven, well above sync latency
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    tick(3);
    scl_out <= 1'b1;
    tick(3);
    r = sda_in;
    tick(3);
    scl_out <= 1'b0;
    // every second low phase one cycle longer: 125 ns bit on average
    tick(odd_r ? 4 : 3);
    odd_r = ~odd_r;
  endtask : bit_io
  task automatic start();
    sda_out <= 1'b1;
    tick(3);
    scl_out <= 1'b1;
    tick(6);
    sda_out <= 1'b0;
    tick(6);
    scl_out <= 1'b0;
    tick(3);
  endtask : start
  task automatic stop();
    sda_out <= 1'b0;
    tick(3);
    scl_out <= 1'b1;
    tick(6);
    sda_out <= 1'b1;
    tick(6);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask : rbyte
endmodule : i2c_ctrl_model

// ---- tb.sv ----
// self-checking bench for the configuration register bank
// assumes the controller model and checker files compiled first
`timescale 1ns/1ps
module tb;
  logic                       clk_sys_in, rstn_in, inhibit_r, sda_w;
  logic                       sda_out, sda_oe_n_out, nv_store_out, blocked;
  logic                       scl, sda_drv;
  logic [17:0]                addr_r;
  logic [7:0]                 ce_m, wp_m, store_cnt;
  logic                       blk_exp;
  cfg_regs_pkg::nv_image_type nv_in_r, nv_out;
  int                         error_cnt, comparisons, seed;
  assign sda_w = sda_drv & (sda_oe_n_out | sda_out);
  eeprom_addr_and_wprot_regs dut_u (.clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .write_inhibit_pin_in(inhibit_r),
    .nv_image_in(nv_in_r), .nv_image_out(nv_out),
    .nv_store_out(nv_store_out), .array_addr_in(addr_r),
    .array_write_blocked_out(blocked));
  i2c_ctrl_model ctl_u (.clk_in(clk_sys_in), .sda_in(sda_w),
    .scl_out(scl), .sda_out(sda_drv));
  // store pulses seen, restarted by reset
  always @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      store_cnt <= 8'h00;
    end else begin
      store_cnt <= store_cnt + {7'h00, nv_store_out};
    end
  end
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // ----------------------------------------------------------------
  // compares and closing
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_ack(input logic [4:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_ack
  task automatic chk_blk(input logic got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_blk
  task automatic chk_store(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_store
  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // bus frames against the model
  // ----------------------------------------------------------------
  task automatic do_reset(input logic [15:0] img);
    rstn_in <= 1'b0;
    nv_in_r <= img;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    ce_m = img[15:8] & 8'h09;
    wp_m = img[7:0] & 8'h0f;
    chk_reg(nv_out, {ce_m, wp_m});
  endtask : do_reset
  task automatic wr(input logic [7:0] ah, d, input int n, input logic sb3);
    logic [4:0] got, exp;
    logic       ok;
    logic [7:0] st0;
    got = 5'h00;
    st0 = store_cnt;
    ctl_u.start();
    ok = !inhibit_r && !(ah[7:5] == 3'h6 ? ce_m[0]
                         : ah[7:5] != 3'h5 || wp_m[0]);
    exp = (sb3 !== ce_m[3]) ? 5'h00 : {3'b111, ok, 1'b0};
    ctl_u.wbyte({cfg_regs_pkg::DEVICE_TYPE_CODE, sb3, 3'h0}, got[4]);
    if (got[4]) begin
      ctl_u.wbyte({ah[7:5], 5'($random(seed))}, got[3]);
      ctl_u.wbyte(8'($random(seed)), got[2]);
      ctl_u.wbyte(d, got[1]);
      if (got[1] && n > 1) ctl_u.wbyte(d, got[0]);
    end
    ctl_u.stop();
    if (exp[1] && n == 1 && ah[7:5] == 3'h6) ce_m = d & 8'h09;
    else if (exp[1] && n == 1) wp_m = d & 8'h0f;
    chk_ack(got, exp);
    ctl_u.tick(10);
    chk_reg(nv_out, {ce_m, wp_m});
    chk_store(store_cnt - st0, {7'h00, exp[1] && n == 1});
  endtask : wr
  task automatic rd(input logic [7:0] ah, exp);
    logic [7:0] r;
    logic       a;
    ctl_u.start();
    ctl_u.wbyte({cfg_regs_pkg::DEVICE_TYPE_CODE, ce_m[3], 3'h0}, a);
    ctl_u.wbyte(ah, a);
    ctl_u.wbyte(8'h00, a);
    ctl_u.start();
    ctl_u.wbyte({cfg_regs_pkg::DEVICE_TYPE_CODE, ce_m[3], 3'h1}, a);
    ctl_u.rbyte(r);
    ctl_u.stop();
    chk_reg({8'h00, r}, {8'h00, exp});
  endtask : rd
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    error_cnt++;
    end_sim();
  end
  initial begin
    error_cnt = 0;
    comparisons = 0;
    seed = 32'hf7e8;
    rstn_in = 1'b0;
    inhibit_r = 1'b0;
    addr_r = 18'h00000;
    nv_in_r = 16'h0000;
    do_reset(16'($random(seed)));
    do_reset(16'h0000);
    $display("test reset load done");
    inhibit_r <= 1'b1;
    wr(8'ha0, 8'hf6, 1, 1'b0);
    inhibit_r <= 1'b0;
    wr(8'ha0, 8'hf6, 1, 1'b0);
    wr(8'ha0, 8'h08, 2, 1'b0);
    wr(8'h00, 8'h08, 1, 1'b0);
    rd(8'ha0, wp_m);
    $display("test write protect writes done");
    for (int b = 0; b < 5; b++) begin
      wr(8'ha0, (b < 4) ? {5'h01, 2'(b), 1'b0} : 8'h06, 1, 1'b0);
      repeat (8) begin
        addr_r <= 18'($random(seed));
        repeat (3) @(posedge clk_sys_in);
        blk_exp = wp_m[3] && (int'(addr_r[17:16]) >= 3 - int'(wp_m[2:1]));
        chk_blk(blocked, blk_exp);
      end
    end
    $display("test protection regions done");
    wr(8'hc0, 8'hf8, 2, 1'b0);
    wr(8'hc0, 8'hf8, 1, 1'b0);
    wr(8'ha0, 8'h00, 1, 1'b0);
    rd(8'hc0, ce_m);
    wr(8'hc0, 8'h09, 1, 1'b1);
    wr(8'hc0, 8'h00, 1, 1'b1);
    wr(8'ha0, 8'h07, 1, 1'b1);
    wr(8'ha0, 8'h08, 1, 1'b1);
    $display("test locks done");
    end_sim();
  end
endmodule : tb
